/* status_regs_pkg.sv */
package status_regs_pkg;

    localparam logic [7:0] PROFILE_STATUS_OFFSET = 8'h13;
    localparam logic [7:0] PIN_STATUS_OFFSET     = 8'h14;
    localparam logic [7:0] PROFILE_STATUS_RESET  = 8'h00;
    localparam logic [7:0] PIN_STATUS_RESET      = 8'h00;
    localparam int         NUM_LEGACY            = 7;
    localparam int         POS_POWER_ENABLE      = 6;
    localparam int         POS_MODE_TWO          = 5;
    localparam int         POS_MODE_ONE          = 4;
    localparam int         POS_EMULATION         = 3;
    localparam int         POS_POLARITY          = 2;
    localparam int         POS_STATE_LSB         = 0;
    localparam logic [1:0] STATE_SLEEP           = 2'h0;
    localparam logic [1:0] STATE_DETECT          = 2'h1;
    localparam logic [1:0] STATE_ACTIVE          = 2'h2;
    localparam logic [1:0] STATE_ERROR           = 2'h3;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_BUSY = 2'b10
    } rd_state_e;

    // Effective control levels after override selection
    typedef struct packed {
        logic power_enable_control;
        logic mode_select_two;
        logic mode_select_one;
        logic emulation_enable_input;
    } ctrl_levels_s;

    // Register read request and answer
    typedef struct packed {
        logic       rd;
        logic [7:0] addr;
    } reg_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } reg_rsp_s;

endpackage : status_regs_pkg

/* level_mux.sv */
`timescale 1ns/1ps
module level_mux (
    input  wire logic pin_level,
    input  wire logic override_level,
    input  wire logic use_override,
    output logic      level
);
    assign level = use_override ? override_level : pin_level;
endmodule : level_mux

/* profile_and_pin_status_regs.sv */
`timescale 1ns/1ps
module profile_and_pin_status_regs
    import status_regs_pkg::*;
#(
    parameter int LEGACY_COUNT = 7
) (
    input  wire logic                          CLOCK,
    input  wire logic                          SYS_RST,
    input  wire logic [LEGACY_COUNT-1:0]       LEGACY_ACCEPT,
    input  wire logic                          POWER_ENABLE_LEVEL,
    input  wire logic                          POWER_ENABLE_OVERRIDE,
    input  wire logic                          MODE_ONE_LEVEL,
    input  wire logic                          MODE_ONE_OVERRIDE,
    input  wire logic                          MODE_TWO_LEVEL,
    input  wire logic                          MODE_TWO_OVERRIDE,
    input  wire logic                          EMULATION_ENABLE_LEVEL,
    input  wire logic                          EMULATION_ENABLE_OVERRIDE,
    input  wire logic                          PIN_IGNORE,
    input  wire logic                          POLARITY_PIN,
    input  wire logic                          REMOVAL_EVENT,
    input  wire logic                          ACTIVE_MODE_CHANGE,
    input  wire logic [1:0]                    POWER_STATE,
    input  wire logic                          HS_SWITCH_DURING_EMULATION,
    input  wire logic                          CUSTOM_CURRENT_MODE,
    input  wire logic                          BUS_ACCESS,
    input  wire status_regs_pkg::reg_req_s     REG_REQ,
    output status_regs_pkg::reg_rsp_s          REG_RSP,
    output logic                               HS_SWITCH_CLOSE,
    output logic                               CUSTOM_LIMIT_SELECT,
    output logic                               LEGACY_CHARGING,
    output logic                               WAKE_REQUEST,
    output logic [7:0]                         PROFILE_STATUS,
    output logic [7:0]                         PIN_STATUS
);
    import status_regs_pkg::*;

    typedef struct packed {
        logic [6:0]  legacy;
        logic [7:0]  pins;
        logic        pol_loaded;
        logic        pol;
        rd_state_e   rd;
        reg_rsp_s    rsp;
        logic        hs;
        logic        cur;
        logic        chg;
        logic        wake;
        logic        pen_prev;
    } state_s;

    state_s       q_r;
    state_s       d_nxt;
    ctrl_levels_s lv;
    logic         ovr;
    logic         clr;

    assign ovr = PIN_IGNORE;

    level_mux u_pen (.pin_level(POWER_ENABLE_LEVEL), .override_level(POWER_ENABLE_OVERRIDE),
                     .use_override(ovr), .level(lv.power_enable_control));
    level_mux u_mode_two (.pin_level(MODE_TWO_LEVEL), .override_level(MODE_TWO_OVERRIDE),
                          .use_override(ovr), .level(lv.mode_select_two));
    level_mux u_mode_one (.pin_level(MODE_ONE_LEVEL), .override_level(MODE_ONE_OVERRIDE),
                          .use_override(ovr), .level(lv.mode_select_one));
    level_mux u_em (.pin_level(EMULATION_ENABLE_LEVEL), .override_level(EMULATION_ENABLE_OVERRIDE),
                    .use_override(ovr), .level(lv.emulation_enable_input));

    always_comb begin
        logic enabled;
        logic pol_eff;
        enabled = 1'b0;
        pol_eff = q_r.pol_loaded ? q_r.pol : POLARITY_PIN;
        d_nxt = q_r;
        // Enabled when level matches latched polarity
        enabled = (lv.power_enable_control == pol_eff);
        d_nxt.pen_prev = enabled;
        // Flags set by acceptance, cleared on events
        d_nxt.legacy = q_r.legacy | LEGACY_ACCEPT[6:0];
        clr = (q_r.pen_prev && !enabled) || ACTIVE_MODE_CHANGE || REMOVAL_EVENT;
        if (clr) begin
            d_nxt.legacy = 7'h00;
        end
        if (!q_r.pol_loaded) begin
            d_nxt.pol_loaded = 1'b1;
            d_nxt.pol = POLARITY_PIN;
        end
        d_nxt.pins = PIN_STATUS_RESET;
        d_nxt.pins[POS_POWER_ENABLE] = lv.power_enable_control;
        d_nxt.pins[POS_MODE_TWO] = lv.mode_select_two;
        d_nxt.pins[POS_MODE_ONE] = lv.mode_select_one;
        d_nxt.pins[POS_EMULATION] = lv.emulation_enable_input;
        d_nxt.pins[POS_POLARITY] = pol_eff;
        d_nxt.pins[POS_STATE_LSB +: 2] = POWER_STATE;
        // Profile steers switch, limit and charging flag, no alert paths
        d_nxt.chg = |q_r.legacy;
        d_nxt.hs = (|q_r.legacy) && HS_SWITCH_DURING_EMULATION;
        d_nxt.cur = (|q_r.legacy) && CUSTOM_CURRENT_MODE;
        d_nxt.wake = BUS_ACCESS || (REG_REQ.rd && (POWER_STATE == STATE_SLEEP));
        d_nxt.rsp.valid = 1'b0;
        d_nxt.rsp.data = 8'h00;
        case (q_r.rd)
            RD_IDLE: begin
                if (REG_REQ.rd) begin
                    d_nxt.rd = RD_BUSY;
                end
            end
            RD_BUSY: begin
                d_nxt.rd = RD_IDLE;
                d_nxt.rsp.valid = 1'b1;
                if (REG_REQ.addr == PROFILE_STATUS_OFFSET) begin
                    d_nxt.rsp.data = {1'b0, q_r.legacy};
                end else if (REG_REQ.addr == PIN_STATUS_OFFSET) begin
                    d_nxt.rsp.data = q_r.pins;
                    // Host access leaves sleep, so the read answer reports DETECT instead; PIN_STATUS still shows SLEEP
                    if (q_r.pins[POS_STATE_LSB +: 2] == STATE_SLEEP) begin
                        d_nxt.rsp.data[POS_STATE_LSB +: 2] = STATE_DETECT;
                    end
                end
            end
            default: begin
                d_nxt.rd = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            q_r <= '{legacy: PROFILE_STATUS_RESET[6:0], pins: PIN_STATUS_RESET, pol_loaded: 1'b0,
                     pol: 1'b0, rd: RD_IDLE, rsp: '0, hs: 1'b0, cur: 1'b0, chg: 1'b0,
                     wake: 1'b0, pen_prev: 1'b0};
        end else begin
            q_r <= d_nxt;
        end
    end

    assign REG_RSP             = q_r.rsp;
    assign HS_SWITCH_CLOSE     = q_r.hs;
    assign CUSTOM_LIMIT_SELECT = q_r.cur;
    assign LEGACY_CHARGING     = q_r.chg;
    assign WAKE_REQUEST        = q_r.wake;
    assign PROFILE_STATUS      = {1'b0, q_r.legacy};
    assign PIN_STATUS          = q_r.pins;

    chk_flags_clear_event: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (REMOVAL_EVENT || ACTIVE_MODE_CHANGE) |=> (PROFILE_STATUS == 8'h00))
        else $error("flags not cleared");
    chk_flag_set_accept: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (LEGACY_ACCEPT[0] && !REMOVAL_EVENT && !ACTIVE_MODE_CHANGE && !clr) |=> PROFILE_STATUS[0])
        else $error("flag not set");
    chk_bit7_zero: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !PROFILE_STATUS[7] && !PIN_STATUS[7])
        else $error("bit 7 set");
    chk_hs_switch: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (PROFILE_STATUS != 8'h00 && HS_SWITCH_DURING_EMULATION) |=> HS_SWITCH_CLOSE)
        else $error("hs switch wrong");
    chk_cur_limit: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (PROFILE_STATUS == 8'h00) |=> !CUSTOM_LIMIT_SELECT)
        else $error("limit without profile");
    chk_pen_follow: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        q_r.pol_loaded |=> (PIN_STATUS[6] == $past(lv.power_enable_control)))
        else $error("power enable not mirrored");
    chk_mode_follow: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        q_r.pol_loaded |=> (PIN_STATUS[5:4] == $past({lv.mode_select_two, lv.mode_select_one})))
        else $error("mode not mirrored");
    chk_em_follow: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        q_r.pol_loaded |=> (PIN_STATUS[3] == $past(lv.emulation_enable_input)))
        else $error("emulation not mirrored");
    chk_pol_stable: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        q_r.pol_loaded |=> $stable(q_r.pol))
        else $error("polarity changed");
    chk_pol_mirror: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        q_r.pol_loaded |=> (PIN_STATUS[POS_POLARITY] == q_r.pol))
        else $error("polarity not mirrored");
    chk_state_field: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        q_r.pol_loaded |=> (PIN_STATUS[1:0] == $past(POWER_STATE)))
        else $error("state not reported");
    chk_read_answer: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (REG_REQ.rd && q_r.rd == RD_IDLE) |=> ##1 REG_RSP.valid)
        else $error("no read answer");
    chk_wake_sleep: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        BUS_ACCESS |=> WAKE_REQUEST)
        else $error("no wake");
    chk_read_not_sleep: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (REG_RSP.valid && $past(REG_REQ.addr) == PIN_STATUS_OFFSET) |-> (REG_RSP.data[1:0] != STATE_SLEEP))
        else $error("sleep code read");
    chk_hs_open: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (PROFILE_STATUS == 8'h00 || !HS_SWITCH_DURING_EMULATION) |=> !HS_SWITCH_CLOSE)
        else $error("hs switch not open");
    chk_cur_custom: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (PROFILE_STATUS != 8'h00 && CUSTOM_CURRENT_MODE) |=> CUSTOM_LIMIT_SELECT)
        else $error("custom limit missing");
    chk_flags_clear_off: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (q_r.pol_loaded && q_r.pen_prev && lv.power_enable_control != q_r.pol) |=> (PROFILE_STATUS == 8'h00))
        else $error("flags kept on disable");
    chk_flags_sticky: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (PROFILE_STATUS[6] && !clr) |=> PROFILE_STATUS[6])
        else $error("flag lost");
    chk_charging_flag: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (PROFILE_STATUS == 8'h00) |=> !LEGACY_CHARGING)
        else $error("charging without profile");
    chk_read_single: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        REG_RSP.valid |=> !REG_RSP.valid)
        else $error("answer repeated");

    cov_accept: cover property (@(posedge CLOCK) disable iff (SYS_RST) PROFILE_STATUS[6]);
    cov_removal: cover property (@(posedge CLOCK) disable iff (SYS_RST)
        (PROFILE_STATUS != 8'h00) ##1 REMOVAL_EVENT);
    cov_read: cover property (@(posedge CLOCK) disable iff (SYS_RST) REG_RSP.valid);
    cov_sleep_read: cover property (@(posedge CLOCK) disable iff (SYS_RST)
        REG_RSP.valid && (PIN_STATUS[1:0] == STATE_SLEEP));
endmodule : profile_and_pin_status_regs

/* profile_and_pin_status_regs_tb_top.sv */
`timescale 1ns/1ps
module profile_and_pin_status_regs_tb_top;
    import status_regs_pkg::*;
    logic       clock;
    logic       sys_rst;
    logic [9:0] pl;
    logic [8:0] lv;
    logic       polarity;
    logic [1:0] state;
    logic [1:0] cfg;
    reg_req_s   req;
    reg_rsp_s   rsp;
    logic       hs_close;
    logic       cur_sel;
    logic       charging;
    logic       wake;
    logic [7:0] prof;
    logic [7:0] pins;
    logic [7:0] acc;
    int         errors;
    int         cmp_count;

    profile_and_pin_status_regs #(.LEGACY_COUNT(NUM_LEGACY)) DUT (
        .CLOCK(clock), .SYS_RST(sys_rst), .LEGACY_ACCEPT(pl[6:0]),
        .POWER_ENABLE_LEVEL(lv[8]), .POWER_ENABLE_OVERRIDE(lv[7]),
        .MODE_TWO_LEVEL(lv[6]), .MODE_TWO_OVERRIDE(lv[5]),
        .MODE_ONE_LEVEL(lv[4]), .MODE_ONE_OVERRIDE(lv[3]),
        .EMULATION_ENABLE_LEVEL(lv[2]), .EMULATION_ENABLE_OVERRIDE(lv[1]),
        .PIN_IGNORE(lv[0]), .POLARITY_PIN(polarity), .REMOVAL_EVENT(pl[7]),
        .ACTIVE_MODE_CHANGE(pl[8]), .POWER_STATE(state), .HS_SWITCH_DURING_EMULATION(cfg[0]),
        .CUSTOM_CURRENT_MODE(cfg[1]), .BUS_ACCESS(pl[9]), .REG_REQ(req), .REG_RSP(rsp),
        .HS_SWITCH_CLOSE(hs_close), .CUSTOM_LIMIT_SELECT(cur_sel), .LEGACY_CHARGING(charging),
        .WAKE_REQUEST(wake), .PROFILE_STATUS(prof), .PIN_STATUS(pins)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Read one register over the block's request port, bounded wait for valid
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        @(posedge clock);
        req <= '{rd: 1'b1, addr: a};
        @(posedge clock);
        req.rd <= 1'b0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (rsp.valid !== 1'b1 && n < 4);
        if (rsp.valid !== 1'b1) begin
            errors++;
            $display("Error at %0t: read answer missing", $time);
            wrap_up();
        end else begin
            check(rsp.data, exp);
        end
    endtask : rd

    task automatic pulse(input logic [9:0] v);
        @(posedge clock);
        pl <= v;
        @(posedge clock);
        pl <= '0;
    endtask : pulse

    function automatic logic [7:0] pin_exp(input logic [1:0] st);
        pin_exp = lv[0] ? {1'b0, lv[7], lv[5], lv[3], lv[1], 1'b1, st}
                        : {1'b0, lv[8], lv[6], lv[4], lv[2], 1'b1, st};
    endfunction : pin_exp

    initial begin
        errors = 0;
        cmp_count = 0;
        acc = 8'h00;
        sys_rst = 1'b1;
        pl = '0;
        lv = '0;
        polarity = 1'b1;
        state = STATE_DETECT;
        cfg = 2'b01;
        req = '0;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        check(prof, PROFILE_STATUS_RESET);
        rd(PROFILE_STATUS_OFFSET, 8'h00);
        rd(PIN_STATUS_OFFSET, pin_exp(STATE_DETECT));
        // Pins differ from overrides so a wrong source shows
        @(posedge clock);
        polarity <= 1'b0;
        lv <= 9'b100110100;
        for (int s = 1; s < 4; s++) begin
            @(posedge clock);
            state <= s[1:0];
            rd(PIN_STATUS_OFFSET, pin_exp(s[1:0]));
            check(pins, pin_exp(s[1:0]));
        end
        rd(8'h15, 8'h00);
        rd(8'h12, 8'h00);
        // Sticky flags, one profile at a time
        for (int i = 0; i < 7; i++) begin
            pulse(10'(1 << i));
            acc[i] = 1'b1;
            rd(PROFILE_STATUS_OFFSET, acc);
        end
        check(prof, 8'h7f);
        check({7'h0, hs_close}, 8'h01);
        check({7'h0, cur_sel}, 8'h00);
        check({7'h0, charging}, 8'h01);
        @(posedge clock);
        cfg <= 2'b10;
        repeat (3) @(posedge clock);
        #1;
        check({7'h0, hs_close}, 8'h00);
        check({7'h0, cur_sel}, 8'h01);
        // Each clear cause, and clear against set in one cycle
        pulse(10'h080);
        rd(PROFILE_STATUS_OFFSET, 8'h00);
        pulse(10'h040);
        pulse(10'h100);
        rd(PROFILE_STATUS_OFFSET, 8'h00);
        pulse(10'h081);
        rd(PROFILE_STATUS_OFFSET, 8'h00);
        pulse(10'h001);
        rd(PROFILE_STATUS_OFFSET, 8'h01);
        @(posedge clock);
        lv[0] <= 1'b1;
        rd(PROFILE_STATUS_OFFSET, 8'h00);
        rd(PIN_STATUS_OFFSET, pin_exp(STATE_ERROR));
        // Bus activity while asleep
        @(posedge clock);
        state <= STATE_SLEEP;
        pulse(10'h200);
        #1;
        check({7'h0, wake}, 8'h01);
        // Host read while asleep must not show the sleep code
        rd(PIN_STATUS_OFFSET, pin_exp(STATE_DETECT));
        check(pins, pin_exp(STATE_SLEEP));
        wrap_up();
    end
endmodule : profile_and_pin_status_regs_tb_top
